/* File: hdl/pin_sampler.sv */
`default_nettype none

// Three-stage sampler; the level follows only once stages two and three agree
module pin_sampler #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] sync3_q;

  // First stage feeds only the second; agreement filters single-sample glitches
  always_ff @(posedge clk_sys_in) begin
    sync1_q <= raw_in;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Per-bit settle so a skewed bus bit does not hold back the others
      always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
          level_out[i] <= 1'b0;
        end else if (sync2_q[i] == sync3_q[i]) begin
          level_out[i] <= sync3_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hdl/sram_tap.sv */
`default_nettype none
`include "sram_tap_map.svh"

// Behaviour
// - 3-bit instruction, 32-bit ident, 107-cell boundary chains
// - Code 111 selects one-bit bypass register
// - Code 001 captures fixed identification word
// - Code 010 samples pins, outputs high impedance
// - Code 100 samples ring, SRAM undisturbed
// - Code 000 captures ring into boundary chain
// - Ident: revision, part, maker, bit0 one
// - Cell 47 gates output bus under 000
// - Sample input rising, change output falling
// - Five high mode-select edges reset; ident loaded
// - Instruction capture loads low bits 01
module sram_tap #(
  parameter int BSR_LEN = `TAP_BSR_LEN,
  parameter logic [2:0] ID_REVISION = 3'h6, // Arbitrary value
  parameter logic [16:0] ID_PART = 17'h00abc, // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h155 // Arbitrary value
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic [BSR_LEN-1:0] ring_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  output logic [BSR_LEN-1:0] ring_drive_out,
  output logic ring_drive_en_out,
  output logic q_bus_enable_out
);

  localparam int IR_LEN = `TAP_IR_LEN;
  localparam int ID_LEN = `TAP_ID_LEN;

  // Synchronised link signals
  logic [2:0] link_lvl;
  logic [BSR_LEN-1:0] ring_lvl;
  logic tck_prev_q;

  pin_sampler #(.WIDTH(3)) u_link_sampler (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .raw_in({tck_in, tms_in, tdi_in}),
    .level_out(link_lvl)
  );

  // Ring snapshot is asynchronous to the SRAM clock, so it is filtered too
  pin_sampler #(.WIDTH(BSR_LEN)) u_ring_sampler (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .raw_in(ring_in),
    .level_out(ring_lvl)
  );

  wire tck_lvl = link_lvl[2];
  wire tms_lvl = link_lvl[1];
  wire tdi_lvl = link_lvl[0];
  wire tck_rise = tck_lvl & ~tck_prev_q;
  wire tck_fall = ~tck_lvl & tck_prev_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_lvl;
    end
  end

  // Controller state
  sram_tap_pkg::tap_state_t state_q;
  sram_tap_pkg::tap_state_t state_d;

  // Next-state table; five high edges reach reset from anywhere
  always_comb begin
    unique case (state_q)
      sram_tap_pkg::TEST_LOGIC_RESET:
        state_d = tms_lvl ? sram_tap_pkg::TEST_LOGIC_RESET : sram_tap_pkg::RUN_TEST_IDLE;
      sram_tap_pkg::RUN_TEST_IDLE:
        state_d = tms_lvl ? sram_tap_pkg::SELECT_DR : sram_tap_pkg::RUN_TEST_IDLE;
      sram_tap_pkg::SELECT_DR:
        state_d = tms_lvl ? sram_tap_pkg::SELECT_IR : sram_tap_pkg::CAPTURE_DR;
      sram_tap_pkg::CAPTURE_DR:
        state_d = tms_lvl ? sram_tap_pkg::EXIT1_DR : sram_tap_pkg::SHIFT_DR;
      sram_tap_pkg::SHIFT_DR:
        state_d = tms_lvl ? sram_tap_pkg::EXIT1_DR : sram_tap_pkg::SHIFT_DR;
      sram_tap_pkg::EXIT1_DR:
        state_d = tms_lvl ? sram_tap_pkg::UPDATE_DR : sram_tap_pkg::PAUSE_DR;
      sram_tap_pkg::PAUSE_DR:
        state_d = tms_lvl ? sram_tap_pkg::EXIT2_DR : sram_tap_pkg::PAUSE_DR;
      sram_tap_pkg::EXIT2_DR:
        state_d = tms_lvl ? sram_tap_pkg::UPDATE_DR : sram_tap_pkg::SHIFT_DR;
      sram_tap_pkg::UPDATE_DR:
        state_d = tms_lvl ? sram_tap_pkg::SELECT_DR : sram_tap_pkg::RUN_TEST_IDLE;
      sram_tap_pkg::SELECT_IR:
        state_d = tms_lvl ? sram_tap_pkg::TEST_LOGIC_RESET : sram_tap_pkg::CAPTURE_IR;
      sram_tap_pkg::CAPTURE_IR:
        state_d = tms_lvl ? sram_tap_pkg::EXIT1_IR : sram_tap_pkg::SHIFT_IR;
      sram_tap_pkg::SHIFT_IR:
        state_d = tms_lvl ? sram_tap_pkg::EXIT1_IR : sram_tap_pkg::SHIFT_IR;
      sram_tap_pkg::EXIT1_IR:
        state_d = tms_lvl ? sram_tap_pkg::UPDATE_IR : sram_tap_pkg::PAUSE_IR;
      sram_tap_pkg::PAUSE_IR:
        state_d = tms_lvl ? sram_tap_pkg::EXIT2_IR : sram_tap_pkg::PAUSE_IR;
      sram_tap_pkg::EXIT2_IR:
        state_d = tms_lvl ? sram_tap_pkg::UPDATE_IR : sram_tap_pkg::SHIFT_IR;
      sram_tap_pkg::UPDATE_IR:
        state_d = tms_lvl ? sram_tap_pkg::SELECT_DR : sram_tap_pkg::RUN_TEST_IDLE;
    endcase
  end

  // Controller advances only on a recognised rising edge
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_q <= sram_tap_pkg::TEST_LOGIC_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // State decodes
  // Preset on the edge that enters reset, so the fifth high edge already takes effect
  wire to_reset = (state_d == sram_tap_pkg::TEST_LOGIC_RESET);
  wire cap_ir = (state_q == sram_tap_pkg::CAPTURE_IR);
  wire sh_ir = (state_q == sram_tap_pkg::SHIFT_IR);
  wire upd_ir = (state_q == sram_tap_pkg::UPDATE_IR);
  wire cap_dr = (state_q == sram_tap_pkg::CAPTURE_DR);
  wire sh_dr = (state_q == sram_tap_pkg::SHIFT_DR);
  wire upd_dr = (state_q == sram_tap_pkg::UPDATE_DR);

  // Instruction chain
  logic [IR_LEN-1:0] ir_shift_q;
  logic [IR_LEN-1:0] ir_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ir_shift_q <= `TAP_IR_CAPTURE;
      ir_q <= `TAP_OP_IDCODE;
    end else if (tck_rise) begin
      if (to_reset) begin
        ir_q <= `TAP_OP_IDCODE;
      end else if (cap_ir) begin
        ir_shift_q <= `TAP_IR_CAPTURE;
      end else if (sh_ir) begin
        ir_shift_q <= {tdi_lvl, ir_shift_q[IR_LEN-1:1]};
      end else if (upd_ir) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // Instruction decode; reserved codes fall back to bypass as a safe choice
  wire op_extest = (ir_q == `TAP_OP_EXTEST);
  wire op_sample_z = (ir_q == `TAP_OP_SAMPLE_Z);
  wire op_sample = (ir_q == `TAP_OP_SAMPLE);
  sram_tap_pkg::chain_sel_t chain;
  assign chain = (ir_q == `TAP_OP_IDCODE) ? sram_tap_pkg::CHAIN_IDENT :
                 (op_extest | op_sample_z | op_sample) ? sram_tap_pkg::CHAIN_BOUNDARY :
                 sram_tap_pkg::CHAIN_BYPASS;

  // Fixed identification word
  wire [ID_LEN-1:0] id_word = {ID_REVISION, ID_PART, ID_MAKER, 1'b1};

  // Data chains
  logic bypass_q;
  logic [ID_LEN-1:0] id_shift_q;
  logic [BSR_LEN-1:0] bsr_shift_q;
  logic [BSR_LEN-1:0] bsr_upd_q;

  // Bypass captures zero, then shifts one bit of delay
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bypass_q <= 1'b0;
    end else if (tck_rise && chain == sram_tap_pkg::CHAIN_BYPASS) begin
      if (cap_dr) begin
        bypass_q <= 1'b0;
      end else if (sh_dr) begin
        bypass_q <= tdi_lvl;
      end
    end
  end

  // Identification chain loads on capture, LSB leaves first
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      id_shift_q <= '0;
    end else if (tck_rise && chain == sram_tap_pkg::CHAIN_IDENT) begin
      if (cap_dr) begin
        id_shift_q <= id_word;
      end else if (sh_dr) begin
        id_shift_q <= {tdi_lvl, id_shift_q[ID_LEN-1:1]};
      end
    end
  end

  // Boundary chain: MSB nearest the serial input, LSB nearest the output
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bsr_shift_q <= '0;
    end else if (tck_rise && chain == sram_tap_pkg::CHAIN_BOUNDARY) begin
      if (cap_dr) begin
        bsr_shift_q <= ring_lvl;
      end else if (sh_dr) begin
        bsr_shift_q <= {tdi_lvl, bsr_shift_q[BSR_LEN-1:1]};
      end
    end
  end

  // Update latches; the output-enable cell is preset high on test reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bsr_upd_q <= '0;
      bsr_upd_q[`TAP_OE_CELL] <= 1'b1;
    end else if (tck_rise) begin
      if (to_reset) begin
        bsr_upd_q[`TAP_OE_CELL] <= 1'b1;
      end else if (upd_dr && chain == sram_tap_pkg::CHAIN_BOUNDARY) begin
        bsr_upd_q <= bsr_shift_q;
      end
    end
  end

  // Serial output mux; reading the chain LSB before the next rise
  wire tdo_sel = sh_ir ? ir_shift_q[0] :
                 (chain == sram_tap_pkg::CHAIN_IDENT) ? id_shift_q[0] :
                 (chain == sram_tap_pkg::CHAIN_BOUNDARY) ? bsr_shift_q[0] :
                 bypass_q;

  // Output changes on the falling edge so the far end samples a settled bit
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tdo_out <= 1'b0;
      tdo_oe_n_out <= 1'b1;
    end else if (tck_fall) begin
      tdo_out <= tdo_sel;
      tdo_oe_n_out <= ~(sh_ir | sh_dr);
    end
  end

  // Pin-side controls; the ring itself is untouched except under 000
  assign ring_drive_out = bsr_upd_q;
  assign ring_drive_en_out = op_extest;
  assign q_bus_enable_out = op_sample_z ? 1'b0 :
                            op_extest ? bsr_upd_q[`TAP_OE_CELL] : 1'b1;

endmodule

`default_nettype wire

/* File: hdl/sram_tap_map.svh */
`ifndef SRAM_TAP_MAP_SVH
`define SRAM_TAP_MAP_SVH

// Chain lengths
`define TAP_IR_LEN 3
`define TAP_ID_LEN 32
`define TAP_BSR_LEN 107

// Instruction codes
`define TAP_OP_EXTEST 3'h0
`define TAP_OP_IDCODE 3'h1
`define TAP_OP_SAMPLE_Z 3'h2
`define TAP_OP_SAMPLE 3'h4
`define TAP_OP_BYPASS 3'h7

// Capture pattern for the instruction chain, low two bits are 01
`define TAP_IR_CAPTURE 3'h1

// Identification word field positions
`define TAP_ID_REV_HI 31
`define TAP_ID_REV_LO 29
`define TAP_ID_PART_HI 28
`define TAP_ID_PART_LO 12
`define TAP_ID_MAKER_HI 11
`define TAP_ID_MAKER_LO 1

// Internal boundary cell that gates the data output bus
`define TAP_OE_CELL 47

`endif

/* File: hdl/sram_tap_pkg.sv */
`default_nettype none

package sram_tap_pkg;

  // Sixteen controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_t;

  // Data chain selected by the current instruction
  typedef enum logic [1:0] {
    CHAIN_BYPASS, CHAIN_IDENT, CHAIN_BOUNDARY
  } chain_sel_t;

endpackage

`default_nettype wire

/* File: sim/sram_tap_chk.sv */
`default_nettype none
`include "sram_tap_map.svh"

module sram_tap_chk #(
  parameter int BSR_LEN = 107
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic [BSR_LEN-1:0] ring_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_n_out,
  input wire logic [BSR_LEN-1:0] ring_drive_out,
  input wire logic ring_drive_en_out,
  input wire logic q_bus_enable_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tck_q;
  logic [2:0] ones_q;
  logic [2:0] ones_d;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // Raw rises with mode-select high, counted without the design's input filter
  assign ones_d = !(tck_in && !tck_q) ? ones_q : (tms_in ? ones_q + 3'h1 : 3'h0);

  // Edge history for the counter
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tck_q <= 1'b0;
      ones_q <= 3'h0;
    end else begin
      tck_q <= tck_in;
      ones_q <= ones_d;
    end
  end

  // Steps of a test-logic reset and its visible result
  sequence fifth_high_rise;
    tck_in && !tck_q && tms_in && ones_q == 3'h4;
  endsequence
  sequence idle_outputs;
    q_bus_enable_out && !ring_drive_en_out && ring_drive_out[`TAP_OE_CELL];
  endsequence

  reset_idle_a: assert property ($rose(rst_n_in) |-> idle_outputs)
    else $error("outputs off after reset");
  tlr_entry_a: assert property (fifth_high_rise |-> ##[1:12] idle_outputs)
    else $error("no test reset after five high rises");
  oe_cell_a: assert property (
    ring_drive_en_out |-> q_bus_enable_out == ring_drive_out[`TAP_OE_CELL])
    else $error("bus enable not from cell");
  tdo_fall_a: assert property ($changed(tdo_out) |-> !$past(tck_in, 4))
    else $error("serial out moved off a fall");
  oe_fall_a: assert property ($changed(tdo_oe_n_out) |-> !$past(tck_in, 4))
    else $error("serial enable moved off a fall");
  ring_rise_a: assert property ($changed(ring_drive_out) |-> $past(tck_in, 4))
    else $error("update latches moved off a rise");
  qbus_rise_a: assert property ($changed(q_bus_enable_out) |-> $past(tck_in, 4))
    else $error("bus enable moved off a rise");
  // A shift is only entered on a rise with mode-select low, then holds for at least six system clocks
  shift_hold_a: assert property (
    $fell(tdo_oe_n_out) |-> !$past(tms_in, 8) ##1 !tdo_oe_n_out [*5])
    else $error("shift state left too early");
endmodule

`default_nettype wire

/* File: sim/sram_tap_test.sv */
`default_nettype none
`include "sram_tap_map.svh"

module sram_tap_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [106:0] P = {7'h35, {25{4'hc}}};
  localparam logic [106:0] Q = {7'h0b, {25{4'h6}}};
  // Arbitrary identity values
  localparam logic [31:0] ID = {3'h5, 17'h1234c, 11'h2a3, 1'h1};
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe_n, drive_en, qen;
  logic [106:0] ring = '0;
  logic [106:0] drive;
  logic [106:0] d;
  int num_errors = 0;
  int compares = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  sram_tap #(.ID_REVISION(3'h5), .ID_PART(17'h1234c), .ID_MAKER(11'h2a3)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .ring_in(ring), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .ring_drive_out(drive),
    .ring_drive_en_out(drive_en), .q_bus_enable_out(qen));
  tap_ctrl_model i_ctl (.clk_sys_in(clk_sys_in), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n),
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

  task automatic check(input logic [106:0] got, input logic [106:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Loads an instruction; the captured pattern comes out first
  task automatic load(input logic [2:0] code);
    i_ctl.scan(1'b1, {104'h0, code}, 3, d);
    check(d[2:0], 3'h1, "instruction capture");
  endtask

  task automatic t_ident();
    i_ctl.scan(1'b0, '0, 32, d);
    check(d[31:0], ID, "ident word");
  endtask

  task automatic t_bypass();
    load(3'h7);
    i_ctl.scan(1'b0, 107'h5, 4, d);
    check(d[3:0], 4'ha, "bypass delay");
    check(qen, 1'b1, "bypass bus");
  endtask

  task automatic t_preload();
    ring = P;
    load(3'h4);
    i_ctl.scan(1'b0, Q, 107, d);
    check(d, P, "ring sample");
    check(drive, Q, "preload latches");
    check({drive_en, qen}, 2'h1, "sample bus");
  endtask

  // Cell 47 was preloaded low, so the bus must be off under external test
  task automatic t_extest();
    ring = ~P;
    load(3'h0);
    check({drive_en, qen}, 2'h2, "extest bus gate");
    i_ctl.scan(1'b0, Q, 107, d);
    check(d, ~P, "extest capture");
  endtask

  task automatic t_sample_z();
    load(3'h2);
    check(qen, 1'b0, "bus not released");
  endtask

  task automatic t_test_reset();
    logic b;
    repeat (5) i_ctl.step(1'b1, 1'b0, b);
    i_ctl.step(1'b0, 1'b0, b);
    check({drive_en, qen, drive[`TAP_OE_CELL]}, 3'h3, "test reset");
    t_ident();
  endtask

  // Main sequence
  initial begin
    logic b;
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    check({drive_en, qen, drive[`TAP_OE_CELL], tdo_oe_n}, 4'h7, "reset values");
    i_ctl.step(1'b0, 1'b0, b);
    t_ident();
    t_bypass();
    t_preload();
    t_extest();
    t_sample_z();
    t_test_reset();
    finish_test();
  end

  // Watchdog: the run needs well under a millisecond
  initial begin
    #1000000;
    num_errors++;
    finish_test();
  end
endmodule

bind sram_tap sram_tap_chk #(.BSR_LEN(BSR_LEN)) i_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .tck_in(tck_in), .tms_in(tms_in),
  .tdi_in(tdi_in), .ring_in(ring_in), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out),
  .ring_drive_out(ring_drive_out), .ring_drive_en_out(ring_drive_en_out),
  .q_bus_enable_out(q_bus_enable_out));

`default_nettype wire

/* File: sim/tap_ctrl_model.sv */
`default_nettype none

module tap_ctrl_model (
  input wire logic clk_sys_in,
  input wire logic tdo_in,
  input wire logic tdo_oe_n_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q = 1'b0;

  // Test clock stands low between frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end

  // One test clock: set up while low, rise, read the answer before the next fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge clk_sys_in);
    tms_out = tms;
    tdi_out = tdi;
    // Four system clocks low and four high give the 160 ns test clock
    repeat (3) @(negedge clk_sys_in);
    tck_out = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    // A released line reads as the inverse of its last driven value
    tdo = tdo_oe_n_in ? ~last_q : tdo_in;
    if (!tdo_oe_n_in) last_q = tdo_in;
    tck_out = 1'b0;
  endtask

  // Idle to shift, n bits, update, back to idle; reserved codes are never sent
  task automatic scan(input logic ir, input logic [106:0] din, input int n,
                      output logic [106:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    // The update edge lands inside the device a few clocks after the last rise
    repeat (2) @(negedge clk_sys_in);
  endtask
endmodule

`default_nettype wire
